// ==== tmb_defs.svh ====
// Constants of the buffered 16-bit timer: register indices, bit positions,
// reset values and divider counts.
// Assumes it is included by bare name; holds definitions only.
`ifndef TMB_DEFS_SVH
`define TMB_DEFS_SVH

`define TMB_ADDR_W      3
`define TMB_IDX_CNT_LO  3'h0
`define TMB_IDX_CNT_HI  3'h1
`define TMB_IDX_CTRL    3'h2
`define TMB_IDX_GATE    3'h3
`define TMB_IDX_STAT    3'h4

`define TMB_CTRL_ON     0
`define TMB_CTRL_WIDE   1
`define TMB_CTRL_SYNC   2
`define TMB_CTRL_OSC    3
`define TMB_CTRL_PS_LO  4
`define TMB_CTRL_PS_HI  5
`define TMB_CTRL_CS_LO  6
`define TMB_CTRL_CS_HI  7
`define TMB_CFG_DRIVE   4
`define TMB_STAT_OVF    0

`define TMB_CTRL_RST    8'h00
`define TMB_GATE_RST    8'h00
`define TMB_CNT_RST     16'h0000
`define TMB_CNT_MAX     16'hffff
`define TMB_SYS_DIV_END 2'h3

`endif

// ==== tmb_pkg.sv ====
// Types shared by the buffered timer modules.
// Assumes tmb_defs.svh is reachable by bare name.
`include "tmb_defs.svh"

package tmb_pkg;

    typedef logic [7:0]               tmb_byte_t;
    typedef logic [`TMB_ADDR_W-1:0]   tmb_addr_t;

    typedef enum logic [1:0] {
        CS_SYS_DIV4,
        CS_SYS,
        CS_XTAL,
        CS_XTAL_ALT
    } tmb_clk_src_t;

    typedef struct packed {
        logic [15:0] count;
        tmb_byte_t   hbuf;
        tmb_byte_t   ctrl;
        tmb_byte_t   gate;
        logic        ovf_flag;
        logic        ovf_pulse;
        tmb_byte_t   rdata;
        logic [1:0]  div;
    } tmb_top_state_t;

    typedef struct packed {
        logic [2:0] cnt;
    } tmb_ps_state_t;

    typedef struct packed {
        logic en;
        logic drive;
        logic in_prev;
        logic out;
        logic edge_det;
    } tmb_xtal_state_t;

endpackage : tmb_pkg

// ==== tmb_prescaler.sv ====
// Prescaler of the buffered timer: divides the source tick by 1, 2, 4 or 8.
// Assumes src_tick_i is a one-cycle enable in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.svh"

module tmb_prescaler #(
    parameter int PS_W = 3
) (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       src_tick_i,
    input  wire logic       clear_i,
    input  wire logic [1:0] ps_sel_i,
    output logic            tick_o
);
    import tmb_pkg::*;

    tmb_ps_state_t r_reg;
    tmb_ps_state_t r_next;
    logic [2:0]    mask;

    function automatic logic [2:0] ps_mask(input logic [1:0] sel);
        case (sel)
            2'h0:    ps_mask = 3'h0;
            2'h1:    ps_mask = 3'h1;
            2'h2:    ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    endfunction : ps_mask

    assign mask   = ps_mask(ps_sel_i);
    // A clear in the same cycle swallows the tick, so the ratio restarts
    assign tick_o = src_tick_i && ((r_reg.cnt & mask) == mask) && !clear_i;

    always_comb begin
        r_next = r_reg;
        if (srst_i || clear_i) begin // [R05]
            r_next.cnt = 3'h0;
        end else if (src_tick_i) begin
            if ((r_reg.cnt & mask) == mask) begin
                r_next.cnt = 3'h0;
            end else begin
                r_next.cnt = r_reg.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        r_reg <= r_next;
    end

    a_ps_clear_zero: assert property (@(posedge clk_i) disable iff (srst_i) // [R05]
        clear_i |=> (r_reg.cnt == 3'h0) && !tick_o || src_tick_i)
        else $error("prescaler not cleared by a low byte write");

endmodule : tmb_prescaler
`default_nettype wire

// ==== tmb_xtal_ctrl.sv ====
// Low-power crystal oscillator control: enable, drive level, edge detect.
// Assumes the crystal pin input is synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.svh"

module tmb_xtal_ctrl (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic osc_en_i,
    input  wire logic cfg_drive_i,
    input  wire logic xtal_in_i,
    output logic      osc_en_o,
    output logic      drive_high_o,
    output logic      xtal_out_o,
    output logic      edge_o
);
    import tmb_pkg::*;

    tmb_xtal_state_t r_reg;
    tmb_xtal_state_t r_next;

    always_comb begin
        r_next          = r_reg;
        r_next.en       = osc_en_i; // [R06]
        r_next.in_prev  = xtal_in_i;
        // Amplifier output idles low while the oscillator is off
        r_next.out      = osc_en_i && !xtal_in_i;
        r_next.edge_det = r_reg.en && xtal_in_i && !r_reg.in_prev;
        if (srst_i) begin
            r_next       = '0;
            // Drive strength is a configuration strap caught while in reset
            r_next.drive = cfg_drive_i; // [R08]
        end
    end

    always_ff @(posedge clk_i) begin
        r_reg <= r_next;
    end

    assign osc_en_o     = r_reg.en;
    assign drive_high_o = r_reg.drive;
    assign xtal_out_o   = r_reg.out;
    assign edge_o       = r_reg.edge_det;

    a_drive_caught: assert property (@(posedge clk_i) // [R08]
        $fell(srst_i) |-> drive_high_o == $past(cfg_drive_i))
        else $error("drive level not taken from the configuration bit");

    a_drive_held: assert property (@(posedge clk_i) // [R08]
        !srst_i && !$past(srst_i) |-> $stable(drive_high_o))
        else $error("drive level changed outside reset");

    a_edge_gated: assert property (@(posedge clk_i) disable iff (srst_i) // [R06]
        !osc_en_o |-> !xtal_out_o ##1 !edge_o)
        else $error("crystal edge or output while oscillator is off");

endmodule : tmb_xtal_ctrl
`default_nettype wire

// ==== tmb_timer.sv ====
// Top of the 16-bit timer with buffered whole-word access and the
// low-power crystal oscillator control.
// Assumes a single-cycle strobe register port, read data one cycle later.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.svh"

// Functional notes
// R01 - Wide mode maps the count high byte address onto a buffer.
// R02 - Wide mode: reading count low byte copies live high byte into buffer.
// R03 - Wide mode: writing count low byte loads high byte from buffer.
// R04 - Wide mode offers no direct access to the live high byte.
// R05 - Count low byte writes clear the prescaler; buffer writes do not.
// R06 - Crystal oscillator runs only while its control enable bit is set.
// R07 - Enabled crystal oscillator keeps running in power-managed modes.
// R08 - Configuration bit four picks high drive (1) or ultra-low power (0).
// R09 - Software waits its own start-up delay; no ready indication exists.
// R10 - Counter counts prescaled ticks while on; rollover raises a flag.
module tmb_timer (
    input  wire logic               CLK_SYS_I,
    input  wire logic               SRST_I,
    input  wire tmb_pkg::tmb_addr_t ADDR_I,
    input  wire tmb_pkg::tmb_byte_t WDATA_I,
    input  wire logic               WR_I,
    input  wire logic               RD_I,
    output tmb_pkg::tmb_byte_t      RDATA_O,
    input  wire tmb_pkg::tmb_byte_t CFG_WORD_LOW_TWO_I,
    input  wire logic               PWR_MANAGED_I,
    input  wire logic               XTAL_IN_PIN_I,
    output logic                    XTAL_OUT_PIN_O,
    output logic                    XTAL_OSC_EN_O,
    output logic                    XTAL_DRIVE_HIGH_O,
    output logic                    OVF_PULSE_O,
    output logic                    OVF_FLAG_O
);
    import tmb_pkg::*;

    tmb_top_state_t r_reg;
    tmb_top_state_t r_next;

    tmb_clk_src_t clk_src;
    logic         wide;
    logic         osc_run;
    logic         sys_div4;
    logic         src_tick;
    logic         cnt_tick;
    logic         xtal_edge;
    logic         wr_lo;
    logic         wr_hi;
    logic         rd_lo;
    logic         rd_hi;

    function automatic tmb_byte_t rd_mux(input tmb_top_state_t s,
                                         input tmb_addr_t      a);
        case (a)
            `TMB_IDX_CNT_LO: rd_mux = s.count[7:0];
            // Wide mode hides the live high byte behind the buffer
            `TMB_IDX_CNT_HI: begin
                rd_mux = s.ctrl[`TMB_CTRL_WIDE] ? s.hbuf : s.count[15:8];
            end
            `TMB_IDX_CTRL:   rd_mux = s.ctrl;
            `TMB_IDX_GATE:   rd_mux = s.gate;
            `TMB_IDX_STAT:   rd_mux = {7'h00, s.ovf_flag};
            default:         rd_mux = 8'h00;
        endcase
    endfunction : rd_mux

    assign clk_src  = tmb_clk_src_t'(r_reg.ctrl[`TMB_CTRL_CS_HI:`TMB_CTRL_CS_LO]);
    assign wide     = r_reg.ctrl[`TMB_CTRL_WIDE];
    // Not gated by the power-managed input: the crystal stays alive [R07]
    assign osc_run  = r_reg.ctrl[`TMB_CTRL_OSC];
    assign sys_div4 = (r_reg.div == `TMB_SYS_DIV_END);
    assign wr_lo    = WR_I && (ADDR_I == `TMB_IDX_CNT_LO);
    assign wr_hi    = WR_I && (ADDR_I == `TMB_IDX_CNT_HI);
    assign rd_lo    = RD_I && (ADDR_I == `TMB_IDX_CNT_LO);
    assign rd_hi    = RD_I && (ADDR_I == `TMB_IDX_CNT_HI);

    // System-derived sources stop in power-managed modes; the crystal
    // source does not, so the counter keeps time while the core sleeps
    always_comb begin
        src_tick = 1'b0;
        if (r_reg.ctrl[`TMB_CTRL_ON]) begin // [R10]
            case (clk_src)
                CS_SYS_DIV4: src_tick = sys_div4 && !PWR_MANAGED_I;
                CS_SYS:      src_tick = !PWR_MANAGED_I;
                CS_XTAL:     src_tick = xtal_edge;
                CS_XTAL_ALT: src_tick = xtal_edge;
                default:     src_tick = 1'b0;
            endcase
        end
    end

    tmb_prescaler #(
        .PS_W (3)
    ) u_prescaler (
        .clk_i      (CLK_SYS_I),
        .srst_i     (SRST_I),
        .src_tick_i (src_tick),
        .clear_i    (wr_lo), // [R05]
        .ps_sel_i   (r_reg.ctrl[`TMB_CTRL_PS_HI:`TMB_CTRL_PS_LO]),
        .tick_o     (cnt_tick)
    );

    tmb_xtal_ctrl u_xtal (
        .clk_i        (CLK_SYS_I),
        .srst_i       (SRST_I),
        .osc_en_i     (osc_run), // [R06]
        .cfg_drive_i  (CFG_WORD_LOW_TWO_I[`TMB_CFG_DRIVE]), // [R08]
        .xtal_in_i    (XTAL_IN_PIN_I),
        .osc_en_o     (XTAL_OSC_EN_O),
        .drive_high_o (XTAL_DRIVE_HIGH_O),
        .xtal_out_o   (XTAL_OUT_PIN_O),
        .edge_o       (xtal_edge)
    );

    always_comb begin
        r_next           = r_reg;
        r_next.ovf_pulse = 1'b0;
        r_next.rdata     = 8'h00;
        r_next.div       = r_reg.div + 2'h1;

        // Clear first so a rollover in the same cycle still sets the flag
        if (WR_I && (ADDR_I == `TMB_IDX_STAT) && WDATA_I[`TMB_STAT_OVF]) begin
            r_next.ovf_flag = 1'b0;
        end

        if (cnt_tick) begin // [R10]
            r_next.count = r_reg.count + 16'h0001;
            if (r_reg.count == `TMB_CNT_MAX) begin
                r_next.ovf_flag  = 1'b1;
                r_next.ovf_pulse = 1'b1;
            end
        end

        // Software writes to the count win over a tick in the same cycle
        if (wr_lo) begin
            r_next.count[7:0] = WDATA_I;
            if (wide) begin
                r_next.count[15:8] = r_reg.hbuf; // [R03]
            end
        end
        if (wr_hi) begin
            if (wide) begin
                r_next.hbuf = WDATA_I; // [R01] [R04]
            end else begin
                r_next.count[15:8] = WDATA_I;
            end
        end
        if (WR_I && (ADDR_I == `TMB_IDX_CTRL)) begin
            r_next.ctrl = WDATA_I;
        end
        // Gate bits are held for software only; gating is not modelled
        if (WR_I && (ADDR_I == `TMB_IDX_GATE)) begin
            r_next.gate = WDATA_I;
        end

        if (RD_I) begin
            r_next.rdata = rd_mux(r_reg, ADDR_I); // [R01] [R04]
            if (rd_lo && wide) begin
                r_next.hbuf = r_reg.count[15:8]; // [R02]
            end
        end

        if (SRST_I) begin
            r_next       = '0;
            r_next.count = `TMB_CNT_RST;
            r_next.ctrl  = `TMB_CTRL_RST;
            r_next.gate  = `TMB_GATE_RST;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        r_reg <= r_next;
    end

    assign RDATA_O     = r_reg.rdata;
    assign OVF_PULSE_O = r_reg.ovf_pulse;
    assign OVF_FLAG_O  = r_reg.ovf_flag;

    a_wide_hi_read: assert property (@(posedge CLK_SYS_I) // [R01]
        disable iff (SRST_I)
        rd_hi && wide |=> RDATA_O == $past(r_reg.hbuf))
        else $error("wide high byte read did not return the buffer");

    a_lo_read_snap: assert property (@(posedge CLK_SYS_I) // [R02]
        disable iff (SRST_I)
        rd_lo && wide
        |=> r_reg.hbuf == $past(r_reg.count[15:8])
            && RDATA_O == $past(r_reg.count[7:0]))
        else $error("low byte read did not snapshot the high byte");

    a_lo_write_load: assert property (@(posedge CLK_SYS_I) // [R03]
        disable iff (SRST_I)
        wr_lo && wide |=> r_reg.count == {$past(r_reg.hbuf), $past(WDATA_I)})
        else $error("low byte write did not commit all sixteen bits");

    a_hi_write_isol: assert property (@(posedge CLK_SYS_I) // [R04]
        disable iff (SRST_I)
        wr_hi && wide
        |=> r_reg.hbuf == $past(WDATA_I)
            && (r_reg.count == $past(r_reg.count)
                || r_reg.count == $past(r_reg.count) + 16'h0001))
        else $error("wide high byte write reached the live counter");

    a_hi_no_clear: assert property (@(posedge CLK_SYS_I) // [R05]
        disable iff (SRST_I)
        wr_hi |-> !u_prescaler.clear_i)
        else $error("high byte write cleared the prescaler");

    a_osc_follows: assert property (@(posedge CLK_SYS_I) // [R06]
        disable iff (SRST_I)
        WR_I && ADDR_I == `TMB_IDX_CTRL
        |=> ##1 XTAL_OSC_EN_O == $past(WDATA_I[`TMB_CTRL_OSC], 2))
        else $error("oscillator enable does not follow its control bit");

    a_osc_pm_run: assert property (@(posedge CLK_SYS_I) // [R07]
        disable iff (SRST_I)
        osc_run && PWR_MANAGED_I |=> XTAL_OSC_EN_O)
        else $error("oscillator stopped in a power-managed mode");

    a_rollover: assert property (@(posedge CLK_SYS_I) // [R10]
        disable iff (SRST_I)
        cnt_tick && r_reg.count == `TMB_CNT_MAX && !wr_lo && !wr_hi
        |=> OVF_PULSE_O && OVF_FLAG_O && r_reg.count == 16'h0000)
        else $error("rollover did not raise the flag");

    a_off_hold: assert property (@(posedge CLK_SYS_I) // [R10]
        disable iff (SRST_I)
        !r_reg.ctrl[`TMB_CTRL_ON] && !WR_I |=> $stable(r_reg.count))
        else $error("counter moved while the timer is off");

    // Prescaler phase must always restart on a low byte write
    a_lo_wr_ps_zero: assert property (@(posedge CLK_SYS_I) // [R05]
        disable iff (SRST_I)
        wr_lo |=> u_prescaler.r_reg.cnt == 3'h0)
        else $error("low byte write left the prescaler running");

    a_hi_wr_ps_keep: assert property (@(posedge CLK_SYS_I) // [R05]
        disable iff (SRST_I)
        wr_hi && !src_tick |=> $stable(u_prescaler.r_reg.cnt))
        else $error("high byte write disturbed the prescaler");

    a_plain_hi_wr: assert property (@(posedge CLK_SYS_I) // [R01]
        disable iff (SRST_I)
        wr_hi && !wide |=> r_reg.count[15:8] == $past(WDATA_I))
        else $error("plain high byte write missed the live counter");

    a_wide_lock: assert property (@(posedge CLK_SYS_I) // [R04]
        disable iff (SRST_I)
        wide && !wr_lo && !cnt_tick |=> $stable(r_reg.count))
        else $error("live counter changed without tick or low write");

    a_hbuf_quiet: assert property (@(posedge CLK_SYS_I) // [R02]
        disable iff (SRST_I)
        !wr_hi && !(rd_lo && wide) |=> $stable(r_reg.hbuf))
        else $error("buffer changed without a buffer access");

    a_plain_no_snap: assert property (@(posedge CLK_SYS_I) // [R02]
        disable iff (SRST_I)
        rd_lo && !wide |=> $stable(r_reg.hbuf))
        else $error("plain low byte read touched the buffer");

    a_osc_off: assert property (@(posedge CLK_SYS_I) // [R06]
        disable iff (SRST_I)
        !osc_run |=> !XTAL_OSC_EN_O)
        else $error("oscillator enabled with its control bit clear");

    // The crystal source must not see the power-managed input at all
    a_xtal_src_pm: assert property (@(posedge CLK_SYS_I) // [R07]
        disable iff (SRST_I)
        r_reg.ctrl[`TMB_CTRL_ON] && r_reg.ctrl[`TMB_CTRL_CS_HI]
        |-> src_tick == xtal_edge)
        else $error("crystal source ticks depend on the power mode");

    a_pm_sys_stop: assert property (@(posedge CLK_SYS_I) // [R10]
        disable iff (SRST_I)
        PWR_MANAGED_I && !r_reg.ctrl[`TMB_CTRL_CS_HI] |-> !src_tick)
        else $error("system source ticked in a power-managed mode");

    a_tick_needs_on: assert property (@(posedge CLK_SYS_I) // [R10]
        disable iff (SRST_I)
        !r_reg.ctrl[`TMB_CTRL_ON] |-> !cnt_tick)
        else $error("counter ticked while the timer is off");

    a_pulse_single: assert property (@(posedge CLK_SYS_I) // [R10]
        disable iff (SRST_I)
        OVF_PULSE_O |=> !OVF_PULSE_O)
        else $error("overflow pulse longer than one cycle");

    a_flag_sticky: assert property (@(posedge CLK_SYS_I) // [R10]
        disable iff (SRST_I)
        OVF_FLAG_O && !(WR_I && ADDR_I == `TMB_IDX_STAT) |=> OVF_FLAG_O)
        else $error("overflow flag dropped without a clear");

endmodule : tmb_timer
`default_nettype wire

// ==== tb_tmb_timer.sv ====
// Self-checking testbench of the buffered 16-bit timer.
// Assumes tmb_pkg and tmb_defs.svh are available; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.svh"

module tb_tmb_timer;
    import tmb_pkg::*;

    localparam int        LIMIT = 8000;
    localparam tmb_addr_t A_LO  = `TMB_IDX_CNT_LO;
    localparam tmb_addr_t A_HI  = `TMB_IDX_CNT_HI;
    localparam tmb_addr_t A_CT  = `TMB_IDX_CTRL;
    localparam tmb_addr_t A_GT  = `TMB_IDX_GATE;
    localparam tmb_addr_t A_ST  = `TMB_IDX_STAT;

    logic      clk_sys;
    logic      srst;
    tmb_addr_t addr;
    tmb_byte_t wdata;
    logic      wr;
    logic      rd;
    tmb_byte_t rdata;
    tmb_byte_t cfg;
    logic      pwr_mgd;
    logic      xin = 1'b0;
    logic      xout;
    logic      osc_en;
    logic      drv_hi;
    logic      ovf_pulse;
    logic      ovf_flag;
    logic      xrun;
    int        xcnt = 0;
    int        cyc = 0;
    int        mismatches;
    int        checks_done;
    tmb_byte_t d;

    tmb_timer uut (
        .CLK_SYS_I          (clk_sys),
        .SRST_I             (srst),
        .ADDR_I             (addr),
        .WDATA_I            (wdata),
        .WR_I               (wr),
        .RD_I               (rd),
        .RDATA_O            (rdata),
        .CFG_WORD_LOW_TWO_I (cfg),
        .PWR_MANAGED_I      (pwr_mgd),
        .XTAL_IN_PIN_I      (xin),
        .XTAL_OUT_PIN_O     (xout),
        .XTAL_OSC_EN_O      (osc_en),
        .XTAL_DRIVE_HIGH_O  (drv_hi),
        .OVF_PULSE_O        (ovf_pulse),
        .OVF_FLAG_O         (ovf_flag)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Crystal pin rises every 6 cycles, and stands still when stopped
    always @(posedge clk_sys) begin
        if (xrun) begin
            xcnt <= (xcnt == 2) ? 0 : xcnt + 1;
            if (xcnt == 2) xin <= ~xin;
        end
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            mismatches = mismatches + 1;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrb(input tmb_addr_t a, input tmb_byte_t v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask : wrb

    // Read data stands only in the cycle after the strobe edge
    task automatic rdb(input tmb_addr_t a, output tmb_byte_t v);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask : rdb

    // 96 cycles is a whole number of periods for every source and divider
    task automatic rate(input tmb_byte_t c, input logic [7:0] exp);
        tmb_byte_t d0;
        tmb_byte_t d1;
        wrb(A_CT, c);
        rdb(A_LO, d0);
        repeat (94) @(posedge clk_sys);
        rdb(A_LO, d1);
        chk("ticks in 96 cycles", {8'h00, exp}, {8'h00, d1 - d0});
    endtask : rate

    task automatic t_regs();
        rdb(A_CT, d);
        chk("control reset", 16'h0000, {8'h00, d});
        wrb(A_GT, 8'ha5);
        rdb(A_GT, d);
        chk("gate readback", 16'h00a5, {8'h00, d});
        wrb(3'h5, 8'hff);
        rdb(3'h5, d);
        chk("unmapped read", 16'h0000, {8'h00, d});
        $display("test regs done");
    endtask : t_regs

    task automatic t_wide();
        wrb(A_CT, 8'h00);
        wrb(A_HI, 8'h12);
        wrb(A_LO, 8'h34);
        wrb(A_CT, 8'h02);
        rdb(A_LO, d);
        chk("low byte", 16'h0034, {8'h00, d});
        rdb(A_HI, d);
        chk("buffer after low read", 16'h0012, {8'h00, d});
        wrb(A_HI, 8'hab);
        rdb(A_HI, d);
        chk("buffer not live", 16'h00ab, {8'h00, d});
        wrb(A_CT, 8'h00);
        rdb(A_HI, d);
        chk("live high untouched", 16'h0012, {8'h00, d});
        wrb(A_CT, 8'h02);
        wrb(A_LO, 8'h56);
        wrb(A_CT, 8'h00);
        rdb(A_HI, d);
        chk("high from buffer", 16'h00ab, {8'h00, d});
        rdb(A_LO, d);
        chk("low written", 16'h0056, {8'h00, d});
        $display("test wide done");
    endtask : t_wide

    task automatic t_rates();
        for (int cs = 0; cs < 2; cs++) begin
            for (int ps = 0; ps < 4; ps++) begin
                rate({cs[1:0], ps[1:0], 4'h1}, 8'(96 / ((cs ? 1 : 4) << ps)));
            end
        end
        rate(8'h40, 8'h00);
        $display("test rates done");
    endtask : t_rates

    // Without the clear some phase would show two ticks; a buffer write
    // that cleared it would show none
    task automatic t_clear();
        wrb(A_CT, 8'h73);
        for (int ph = 0; ph < 8; ph++) begin
            repeat (ph) @(posedge clk_sys);
            wrb(A_LO, 8'h00);
            wrb(A_HI, 8'h00);
            repeat (6) @(posedge clk_sys);
            rdb(A_LO, d);
            chk("one tick after low write", 16'h0001, {8'h00, d});
        end
        $display("test clear done");
    endtask : t_clear

    task automatic t_ovf();
        int n;
        wrb(A_CT, 8'h02);
        wrb(A_HI, 8'hff);
        wrb(A_LO, 8'hfd);
        wrb(A_CT, 8'h43);
        n = 0;
        while (ovf_pulse !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("overflow pulse", 16'h0001, {15'h0, ovf_pulse});
        @(posedge clk_sys);
        #1;
        chk("pulse one cycle", 16'h0000, {15'h0, ovf_pulse});
        chk("overflow flag", 16'h0001, {15'h0, ovf_flag});
        wrb(A_CT, 8'h02);
        rdb(A_ST, d);
        chk("status flag", 16'h0001, {8'h00, d});
        wrb(A_ST, 8'h01);
        rdb(A_ST, d);
        chk("status cleared", 16'h0000, {8'h00, d});
        $display("test overflow done");
    endtask : t_ovf

    task automatic t_xtal();
        wrb(A_CT, 8'h08);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("osc enable", 16'h0001, {15'h0, osc_en});
        xrun    <= 1'b1;
        pwr_mgd <= 1'b1;
        rate(8'h89, 8'd16);
        rate(8'hc9, 8'd16);
        chk("osc in low power", 16'h0001, {15'h0, osc_en});
        xrun <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("amplifier out", {15'h0, ~xin}, {15'h0, xout});
        // Stop the oscillator first so no late edge leaks into the window
        wrb(A_CT, 8'h80);
        xrun <= 1'b1;
        rate(8'h81, 8'h00);
        xrun    <= 1'b0;
        pwr_mgd <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("osc disabled", 16'h0000, {15'h0, osc_en});
        chk("amplifier off", 16'h0000, {15'h0, xout});
        $display("test crystal done");
    endtask : t_xtal

    task automatic t_strap();
        @(posedge clk_sys);
        cfg  <= 8'h00;
        srst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        chk("low drive strap", 16'h0000, {15'h0, drv_hi});
        chk("flag after reset", 16'h0000, {15'h0, ovf_flag});
        $display("test strap done");
    endtask : t_strap

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    initial begin
        srst        = 1'b1;
        addr        = '0;
        wdata       = '0;
        wr          = 1'b0;
        rd          = 1'b0;
        cfg         = 8'h10;
        pwr_mgd     = 1'b0;
        xrun        = 1'b0;
        mismatches  = 0;
        checks_done = 0;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        chk("high drive strap", 16'h0001, {15'h0, drv_hi});
        chk("osc off at reset", 16'h0000, {15'h0, osc_en});
        t_regs();
        t_wide();
        t_rates();
        t_clear();
        t_ovf();
        t_xtal();
        t_strap();
        final_report();
    end

endmodule : tb_tmb_timer
`default_nettype wire
